//--- core/fsr_pkg.sv
// shared constants and types for the five-level serial receiver.
// assumes one 200 mhz clock and a logic-level serial input.
`default_nettype none

package fsr_pkg;
  // clock rate
  localparam int unsigned CLK_MHZ = 200;
  // select pulse times in microseconds, one per speed
  localparam int unsigned PULSE_US_60  = 22000;
  localparam int unsigned PULSE_US_66  = 20000;
  localparam int unsigned PULSE_US_75  = 17570;
  localparam int unsigned PULSE_US_100 = 13470;
  // select pulse lengths in clock cycles
  localparam int unsigned PULSE_CYC_60  = PULSE_US_60 * CLK_MHZ;
  localparam int unsigned PULSE_CYC_66  = PULSE_US_66 * CLK_MHZ;
  localparam int unsigned PULSE_CYC_75  = PULSE_US_75 * CLK_MHZ;
  localparam int unsigned PULSE_CYC_100 = PULSE_US_100 * CLK_MHZ;
  // mid-pulse sample point as a fraction of a pulse
  localparam int unsigned SAMPLE_NUM = 7;
  localparam int unsigned SAMPLE_DEN = 16;
  localparam int unsigned CNT_W      = 23;
  // frame shape
  localparam int unsigned DATA_BITS = 5;
  localparam logic [2:0]  LAST_BIT  = 3'h4;
  // speed select encodings
  localparam logic [1:0] SPD_60  = 2'h0;
  localparam logic [1:0] SPD_66  = 2'h1;
  localparam logic [1:0] SPD_75  = 2'h2;
  localparam logic [1:0] SPD_100 = 2'h3;
  // character codes, first data pulse in bit 0, mark is 1
  localparam logic [4:0] CODE_BLANK = 5'h00;
  localparam logic [4:0] CODE_LF    = 5'h02;
  localparam logic [4:0] CODE_SPACE = 5'h04;
  localparam logic [4:0] CODE_CR    = 5'h08;
  localparam logic [4:0] CODE_FIGS  = 5'h1b;
  localparam logic [4:0] CODE_LTRS  = 5'h1f;
  // case flag values
  localparam logic CASE_LTRS = 1'b1;
  localparam logic CASE_FIGS = 1'b0;
  // register map
  localparam int unsigned ADDR_W    = 4;
  localparam logic [3:0]  ADDR_CTRL = 4'h0;
  localparam logic [3:0]  ADDR_STAT = 4'h4;
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam int unsigned CTRL_AUTO = 2;
  localparam int unsigned STAT_CASE = 0;
  localparam int unsigned STAT_REQ  = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam int unsigned STAT_CODE = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // receiver states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_VERIFY = 4'h2,
    ST_DATA   = 4'h4,
    ST_STOP   = 4'h8
  } fsr_state_t;

  // control codes never reach the page memory
  function automatic logic fsr_is_control(input logic [4:0] code);
    return (code == CODE_BLANK) || (code == CODE_LF) || (code == CODE_CR) ||
           (code == CODE_FIGS) || (code == CODE_LTRS);
  endfunction
endpackage

`default_nettype wire

//--- core/fsr_pulse_timer.sv
// select pulse timer: first tick at seven sixteenths, then one per pulse.
// assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module fsr_pulse_timer (
  input  wire  logic                       aclk,       // system clock
  input  wire  logic                       aresetn,    // sync reset, low
  input  wire  logic                       run,        // frame in progress
  input  wire  logic                       start,      // start edge seen
  input  wire  logic [fsr_pkg::CNT_W-1:0]  pulse_cyc,  // pulse length
  output logic                             tick        // sample strobe
);
  import fsr_pkg::*;

  logic [CNT_W-1:0] cnt_reg, cnt_next;        // cycles to next tick
  logic [CNT_W-1:0] period_reg, period_next;  // pulse length of frame

  // count down; speed is taken only at the start edge
  always_comb begin
    cnt_next    = cnt_reg;
    period_next = period_reg;
    tick        = 1'b0;
    if (start) begin
      // start arrives while run is still low, so it must win over the idle clear
      period_next = pulse_cyc;
      cnt_next = CNT_W'((32'(pulse_cyc) * SAMPLE_NUM) / SAMPLE_DEN - 32'h1);
    end else if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg == '0) begin
      tick     = 1'b1;
      cnt_next = period_reg - CNT_W'(1);
    end else begin
      cnt_next = cnt_reg - CNT_W'(1);
    end
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg    <= '0;
      period_reg <= '0;
    end else begin
      cnt_reg    <= cnt_next;
      period_reg <= period_next;
    end
  end
endmodule // fsr_pulse_timer

`default_nettype wire

//--- core/fsr_receiver.sv
// five-level start/stop receiver with case tracking and memory handshake.
// assumes a logic-level serial pin, front panel buttons as pins, axi4-lite.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - frame: start, five data, stop pulse
// - steady mark line means idle
// - mark to space edge begins a frame
// - start and data share one pulse length
// - pulse length set by chosen speed
// - capture exactly the five data pulses
// - speed may change at any time
// - space forces letters when option enabled
// - letters button injects a letters shift
// - held letters button beats received shifts
// - newline button makes a line feed
// - every line feed brings a carriage return
// - classify character, hold until memory takes
// - low input is mark, high is space
// - resample start at seven sixteenths pulse
// - shift codes set case, sent as bit
// - control codes are never stored
// - request, then wait for resume
module fsr_receiver #(
  parameter int unsigned PULSE_CYC_60  = fsr_pkg::PULSE_CYC_60,
  parameter int unsigned PULSE_CYC_66  = fsr_pkg::PULSE_CYC_66,
  parameter int unsigned PULSE_CYC_75  = fsr_pkg::PULSE_CYC_75,
  parameter int unsigned PULSE_CYC_100 = fsr_pkg::PULSE_CYC_100
) (
  input  wire  logic                        aclk,                 // system clock
  input  wire  logic                        aresetn,              // sync reset, low
  input  wire  logic [fsr_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire  logic                        s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire  logic [31:0]                 s_axi_wdata,
  input  wire  logic [3:0]                  s_axi_wstrb,
  input  wire  logic                        s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire  logic                        s_axi_bready,
  input  wire  logic [fsr_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire  logic                        s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire  logic                        s_axi_rready,
  input  wire  logic                        serial_in,            // line pin
  input  wire  logic                        force_letters_button, // held high
  input  wire  logic                        force_newline_button, // held high
  output logic                              char_req,             // char ready
  output logic [4:0]                        char_code,            // five bits
  output logic                              char_case,            // sixth bit
  input  wire  logic                        char_resume,          // memory done
  output logic                              line_feed,            // pulse
  output logic                              carriage_return       // pulse
);
  import fsr_pkg::*;

  // ---- pin synchronisers ----
  logic [2:0] meta_reg, sync_reg;  // serial, letters, newline
  logic       nl_prev_reg;         // newline button last level
  logic       rx_space;            // line in space state
  logic       ltrs_held;           // letters button held
  logic       nl_press;            // newline button edge

  // two flops per pin before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg    <= 3'h0;
      sync_reg    <= 3'h0;
      nl_prev_reg <= 1'b0;
    end else begin
      meta_reg    <= {force_newline_button, force_letters_button, serial_in};
      sync_reg    <= meta_reg;
      nl_prev_reg <= sync_reg[2];
    end
  end

  assign rx_space  = sync_reg[0];
  assign ltrs_held = sync_reg[1];
  assign nl_press  = sync_reg[2] & ~nl_prev_reg;

  // ---- control register ----
  logic [2:0] ctrl_reg, ctrl_next;  // speed and auto letters
  logic       auto_letters_on_blank_enable;
  logic [1:0] words_per_minute_speed;
  logic [CNT_W-1:0] pulse_cyc;      // current pulse length

  assign words_per_minute_speed       = ctrl_reg[1:0];
  assign auto_letters_on_blank_enable = ctrl_reg[CTRL_AUTO];

  // speed to pulse length
  always_comb begin
    unique case (words_per_minute_speed)
      SPD_60:  pulse_cyc = CNT_W'(PULSE_CYC_60);
      SPD_66:  pulse_cyc = CNT_W'(PULSE_CYC_66);
      SPD_75:  pulse_cyc = CNT_W'(PULSE_CYC_75);
      SPD_100: pulse_cyc = CNT_W'(PULSE_CYC_100);
    endcase
  end

  // ---- frame state machine ----
  fsr_state_t state_reg, state_next;
  logic [2:0] bit_reg, bit_next;      // data pulses taken
  logic [4:0] shift_reg, shift_next;  // data shift register
  logic       done_reg, done_next;    // character complete
  logic       start_edge;             // begin verify
  logic       tick;                   // sample strobe
  logic       req_reg, req_next;

  // idle, start check, five data samples, stop wait
  always_comb begin
    state_next = state_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    done_next  = 1'b0;
    start_edge = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        // mark keeps us idle, space is the start edge
        if (rx_space) begin
          start_edge = 1'b1;
          state_next = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        // transient unless space still present
        if (tick) begin
          bit_next   = 3'h0;
          state_next = rx_space ? ST_DATA : ST_IDLE;
        end
      end
      ST_DATA: begin
        // mark samples as one, first pulse into bit 0
        if (tick) begin
          shift_next = {~rx_space, shift_reg[4:1]};
          bit_next   = bit_reg + 3'h1;
          if (bit_reg == LAST_BIT) begin
            done_next  = 1'b1;
            state_next = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        // any stop length; wait for mark and for resume
        if (!rx_space && !done_reg && !req_reg) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // frame registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      bit_reg   <= 3'h0;
      shift_reg <= 5'h00;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      done_reg  <= done_next;
    end
  end

  // pulse timing for the frame
  fsr_pulse_timer u_timer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (state_reg != ST_IDLE),
    .start     (start_edge),
    .pulse_cyc (pulse_cyc),
    .tick      (tick)
  );

  // ---- case, classification and hand-off ----
  logic       case_reg, case_next;
  logic [4:0] code_reg, code_next;    // held character
  logic       ccase_reg, ccase_next;  // case sent with it
  logic       lf_reg, lf_next;
  logic       cr_reg, cr_next;

  // decode the finished character
  always_comb begin
    case_next  = case_reg;
    code_next  = code_reg;
    ccase_next = ccase_reg;
    req_next   = req_reg;
    lf_next    = 1'b0;
    cr_next    = lf_reg;
    if (done_reg) begin
      if (shift_reg == CODE_LTRS) begin
        case_next = CASE_LTRS;
      end else if (shift_reg == CODE_FIGS) begin
        case_next = CASE_FIGS;
      end else if (shift_reg == CODE_SPACE && auto_letters_on_blank_enable) begin
        case_next = CASE_LTRS;
      end
      if (shift_reg == CODE_LF) begin
        lf_next = 1'b1;
      end
    end
    // held button overrides any received shift
    if (ltrs_held) begin
      case_next = CASE_LTRS;
    end
    if (nl_press) begin
      lf_next = 1'b1;
    end
    if (req_reg && char_resume) begin
      req_next = 1'b0;
    end
    // printing characters only, request wins over resume
    if (done_reg && !fsr_is_control(shift_reg)) begin
      code_next  = shift_reg;
      ccase_next = case_next;
      req_next   = 1'b1;
    end
  end

  // hand-off registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      case_reg  <= CASE_LTRS;
      code_reg  <= 5'h00;
      ccase_reg <= CASE_LTRS;
      req_reg   <= 1'b0;
      lf_reg    <= 1'b0;
      cr_reg    <= 1'b0;
    end else begin
      case_reg  <= case_next;
      code_reg  <= code_next;
      ccase_reg <= ccase_next;
      req_reg   <= req_next;
      lf_reg    <= lf_next;
      cr_reg    <= cr_next;
    end
  end

  assign char_req        = req_reg;
  assign char_code       = code_reg;
  assign char_case       = ccase_reg;
  assign line_feed       = lf_reg;
  assign carriage_return = cr_reg;

  // ---- axi4-lite slave ----
  logic        aw_full_reg, aw_full_next;
  logic [3:0]  aw_addr_reg, aw_addr_next;
  logic        w_full_reg, w_full_next;
  logic [31:0] w_data_reg, w_data_next;
  logic        w_lane0_reg, w_lane0_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] status_word;           // live status

  // status view of block state
  always_comb begin
    status_word = 32'h0;
    status_word[STAT_CASE] = case_reg;
    status_word[STAT_REQ]  = req_reg;
    status_word[STAT_BUSY] = (state_reg != ST_IDLE);
    status_word[STAT_CODE +: 5] = code_reg;
  end

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_arready = ~rvalid_reg;

  // address and data taken in either order, answer after both
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    ctrl_next    = ctrl_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next  = 1'b1;
      w_data_next  = s_axi_wdata;
      w_lane0_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      if (aw_addr_reg == ADDR_CTRL) begin
        // speed change accepted at any time
        if (w_lane0_reg) begin
          ctrl_next = w_data_reg[2:0];
        end
      end else if (aw_addr_reg != ADDR_STAT) begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = 32'h0;
      if (s_axi_araddr == ADDR_CTRL) begin
        rdata_next[2:0] = ctrl_reg;
      end else if (s_axi_araddr == ADDR_STAT) begin
        rdata_next = status_word;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  // bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      ctrl_reg    <= CTRL_RST;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      ctrl_reg    <= ctrl_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  // ---- checks ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_idle_on_mark: assert property (
    (state_reg == ST_IDLE && !rx_space) |=> state_reg == ST_IDLE)
    else $error("left idle on mark");
  chk_start_edge: assert property (
    $rose(state_reg == ST_VERIFY) |-> $past(rx_space) && $past(state_reg == ST_IDLE))
    else $error("verify without space edge");
  chk_glitch_drop: assert property (
    (state_reg == ST_VERIFY && tick && !rx_space) |=> state_reg == ST_IDLE)
    else $error("transient accepted as start");
  chk_five_bits: assert property (
    (state_reg == ST_DATA && tick && bit_reg == LAST_BIT) |=> done_reg ##1 !done_reg)
    else $error("character not done after fifth pulse");
  chk_req_hold: assert property (
    (req_reg && !char_resume) |=> req_reg && $stable(code_reg) && $stable(ccase_reg))
    else $error("request dropped before resume");
  chk_no_ctrl_store: assert property (
    (done_reg && fsr_is_control(shift_reg) && !req_reg) |=> !req_reg)
    else $error("control code requested");
  chk_lf_then_cr: assert property (
    lf_reg |=> cr_reg)
    else $error("line feed without carriage return");
  chk_force_letters: assert property (
    ltrs_held |=> case_reg == CASE_LTRS)
    else $error("held letters button lost");
  chk_auto_letters: assert property (
    (done_reg && shift_reg == CODE_SPACE && auto_letters_on_blank_enable) |=> case_reg == CASE_LTRS)
    else $error("space did not force letters");
  chk_no_next_char: assert property (
    (state_reg == ST_STOP && req_reg) |=> state_reg == ST_STOP)
    else $error("next frame before resume");
endmodule // fsr_receiver

`default_nettype wire

//--- tb/fsr_tu_model.sv
// terminal unit model: drives the logic-level serial line, high is space.
// assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module fsr_tu_model (
  input  wire logic aclk,     // system clock
  output logic      line_out  // serial line to the receiver
);
  // rest state is a steady mark
  initial line_out = 1'b0;

  // drive one level for n clock cycles
  task automatic hold(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge aclk);
  endtask

  // one frame: space start, five data, mark stop of stop_n pulses
  task automatic send(input logic [4:0] code, input int p, input int stop_n);
    hold(1'b1, p);
    for (int i = 0; i < 5; i++) hold(~code[i], p);    // mark is low
    hold(1'b0, p * stop_n);
  endtask

  // short space burst that must not count as a start
  task automatic glitch(input int n);
    hold(1'b1, n);
    hold(1'b0, 1);
  endtask
endmodule // fsr_tu_model

`default_nettype wire

//--- tb/five_level_serial_receiver_test.sv
// self-checking bench for the five-level receiver: axi register access,
// frames from the terminal unit model, the page memory side and the buttons.
`timescale 1ns/1ps
`default_nettype none

module five_level_serial_receiver_test;
  import fsr_pkg::*;
  // shortened pulse lengths per speed, and one printing code per speed
  localparam int         PC [4] = '{160, 144, 128, 112};
  localparam logic [4:0] PK [4] = '{5'h01, 5'h03, 5'h07, 5'h1e};

  logic        aclk                 = 1'b0;   // system clock
  logic        aresetn              = 1'b0;   // sync reset
  logic [3:0]  awaddr               = 4'h0;   // axi write address
  logic        awvalid              = 1'b0;
  logic        awready;
  logic [31:0] wdata                = 32'h0;
  logic        wvalid               = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready               = 1'b0;
  logic [3:0]  araddr               = 4'h0;   // axi read address
  logic        arvalid              = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready               = 1'b0;
  logic        serial_line;                   // from terminal unit
  logic        force_letters_button = 1'b0;   // panel buttons
  logic        force_newline_button = 1'b0;
  logic        char_req;                      // page memory side
  logic [4:0]  char_code;
  logic        char_case;
  logic        char_resume          = 1'b0;
  logic        line_feed;
  logic        carriage_return;
  logic        lf_d                 = 1'b0;   // line feed one cycle ago
  int          lf_cnt               = 0;      // line feed pulses seen
  int          cr_cnt               = 0;      // returns right after a line feed
  int          err_count            = 0;
  int          cmp_count            = 0;

  always #2.5 aclk = ~aclk;

  fsr_receiver #(
    .PULSE_CYC_60  (PC[0]),
    .PULSE_CYC_66  (PC[1]),
    .PULSE_CYC_75  (PC[2]),
    .PULSE_CYC_100 (PC[3])
  ) u_dut (
    .aclk (aclk), .aresetn (aresetn),
    .s_axi_awaddr (awaddr), .s_axi_awvalid (awvalid), .s_axi_awready (awready),
    .s_axi_wdata (wdata), .s_axi_wstrb (4'hf), .s_axi_wvalid (wvalid), .s_axi_wready (wready),
    .s_axi_bresp (bresp), .s_axi_bvalid (bvalid), .s_axi_bready (bready),
    .s_axi_araddr (araddr), .s_axi_arvalid (arvalid), .s_axi_arready (arready),
    .s_axi_rdata (rdata), .s_axi_rresp (rresp), .s_axi_rvalid (rvalid), .s_axi_rready (rready),
    .serial_in (serial_line), .force_letters_button (force_letters_button),
    .force_newline_button (force_newline_button), .char_req (char_req), .char_code (char_code),
    .char_case (char_case), .char_resume (char_resume), .line_feed (line_feed),
    .carriage_return (carriage_return)
  );

  fsr_tu_model u_tu (.aclk (aclk), .line_out (serial_line));

  // count line feeds and the return that must follow each one cycle later
  always @(posedge aclk) begin
    lf_d <= line_feed;
    if (line_feed === 1'b1) lf_cnt++;
    if (carriage_return === 1'b1 && lf_d === 1'b1) cr_cnt++;
  end

  // compare one value, report a mismatch at once
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // axi write: address and data offered together, each released when taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    int   n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (!aw && !w && bvalid === 1'b1) break;
      if (n > 100) begin
        err_count++;
        $display("Error at %0t: write not answered", $time);
        break;
      end
    end
    bready <= 1'b0;
    check_word({30'h0, bresp}, {30'h0, er});
  endtask

  // axi read: hold the address until taken, rready until rvalid
  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    check_word(rdata, ed);
    check_word({30'h0, rresp}, {30'h0, er});
  endtask

  // wait for a request, see it stand, then answer with one resume cycle
  task automatic expect_char(input logic [4:0] code, input logic cs);
    int n;
    n = 0;
    while (char_req !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    repeat (20) @(posedge aclk);
    check_word({26'h0, char_req, char_case, char_code}, {26'h0, 1'b1, cs, code});
    char_resume <= 1'b1;
    @(posedge aclk);
    char_resume <= 1'b0;
    @(posedge aclk);
    check_word({31'h0, char_req}, 32'h0);
  endtask

  // no request pending, and the expected line feed and return totals
  task automatic expect_none(input int lf, input int cr);
    repeat (8) @(posedge aclk);
    check_word({31'h0, char_req}, 32'h0);
    check_word(32'(lf_cnt), 32'(lf));
    check_word(32'(cr_cnt), 32'(cr));
  endtask

  // closing report and verdict
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: the tests need roughly eighteen thousand cycles
  initial begin
    repeat (100000) @(posedge aclk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_read(ADDR_CTRL, 32'h0, RESP_OKAY);
    axi_read(ADDR_STAT, 32'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      axi_write(ADDR_CTRL, 32'(i), RESP_OKAY);
      u_tu.send(PK[i], PC[i], 1);
      expect_char(PK[i], CASE_LTRS);
    end
    axi_write(ADDR_CTRL, 32'h0, RESP_OKAY);
    u_tu.send(CODE_FIGS, PC[0], 1);
    expect_none(0, 0);
    u_tu.send(5'h17, PC[0], 1);
    expect_char(5'h17, CASE_FIGS);
    axi_read(ADDR_STAT, 32'h1700, RESP_OKAY);
    u_tu.send(CODE_SPACE, PC[0], 1);
    expect_char(CODE_SPACE, CASE_FIGS);
    axi_write(ADDR_CTRL, 32'h4, RESP_OKAY);
    u_tu.send(CODE_SPACE, PC[0], 1);
    expect_char(CODE_SPACE, CASE_LTRS);
    u_tu.send(CODE_LF, PC[0], 1);
    expect_none(1, 1);
    u_tu.send(CODE_CR, PC[0], 1);
    u_tu.send(CODE_BLANK, PC[0], 1);
    expect_none(1, 1);
    u_tu.glitch(PC[0] / 4);
    repeat (2 * PC[0]) @(posedge aclk);
    expect_none(1, 1);
    // an accepted glitch would still be mid-frame here, showing busy
    axi_read(ADDR_STAT, 32'h0401, RESP_OKAY);
    u_tu.send(5'h1e, PC[0], 3);
    expect_char(5'h1e, CASE_LTRS);
    // this code decodes wrongly if the new speed leaks into the running frame
    fork
      u_tu.send(5'h13, PC[0], 1);
      begin
        repeat (2 * PC[0]) @(posedge aclk);
        axi_write(ADDR_CTRL, 32'h3, RESP_OKAY);
      end
    join
    expect_char(5'h13, CASE_LTRS);
    u_tu.send(5'h07, PC[3], 1);
    expect_char(5'h07, CASE_LTRS);
    u_tu.send(CODE_FIGS, PC[3], 1);
    axi_read(ADDR_STAT, 32'h0700, RESP_OKAY);
    force_letters_button <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_read(ADDR_STAT, 32'h0701, RESP_OKAY);
    u_tu.send(CODE_FIGS, PC[3], 1);
    u_tu.send(5'h17, PC[3], 1);
    expect_char(5'h17, CASE_LTRS);
    force_letters_button <= 1'b0;
    @(posedge aclk);
    force_newline_button <= 1'b1;
    repeat (6) @(posedge aclk);
    force_newline_button <= 1'b0;
    expect_none(2, 2);
    axi_write(4'h8, 32'h5, RESP_SLVERR);
    axi_write(ADDR_STAT, 32'hffff_ffff, RESP_OKAY);
    axi_read(ADDR_CTRL, 32'h3, RESP_OKAY);
    axi_read(4'h8, 32'h0, RESP_SLVERR);
    results();
  end
endmodule // five_level_serial_receiver_test

`default_nettype wire
